/* design/sar_adc_defines.svh */
/*
  Constants of the converter readout: code width, clock numbering of the
  serial frame, and the hold-time figure.
  Assumes it is included by its bare name; definitions only.
*/
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// result width and scale: code = vin * 2**CODE_SHIFT / ref
`define RESULT_W 12
`define CODE_SHIFT 12
`define CODE_ZERO 12'h000

// serial clock numbering, counted in rising edges after select falls
`define CLK_CNT_W 5
`define CLK_CNT_MAX 5'h1F
`define NULL_CLK 5'h02
`define MSB_LAST_CLK 5'h0E
`define LSB_LAST_CLK 5'h19

// sample hold time, 1.2 ms, kept in microseconds
`define HOLD_TIME_US 1200
`define CORE_CLK_MHZ 250

// synchroniser bit positions
`define SYNC_CNT 4
`define SYNC_SEL 0
`define SYNC_START 1
`define SYNC_SAMPLED 2
`define SYNC_DONE 3

`endif

/* design/sar_adc_pkg.sv */
/*
  Types shared by the converter readout: the result code and the phase
  of the serial frame.
  Assumes sar_adc_defines.svh is on the include path.
*/
`include "sar_adc_defines.svh"

package sar_adc_pkg;

  typedef logic [`RESULT_W-1:0] code_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ACQ,
    PH_NULL,
    PH_MSB,
    PH_LSB,
    PH_ZERO
  } phase_e;

endpackage : sar_adc_pkg

/* design/sar_adc_serial_readout.sv */
/*
  Sequencing and serial readout of a 12-bit successive-approximation
  converter: sample and hold in the core domain, bit-per-clock
  conversion and shifting on the serial clock.
  Assumes the analog levels arrive as unsigned words on core_clk, the
  host keeps the serial clock still for 3 core cycles after select falls,
  and sar_adc_pkg is compiled first.
*/
`timescale 1ns/1ps
`include "sar_adc_defines.svh"

module sar_adc_serial_readout #(
  parameter int ANALOG_W = 16,
  parameter int HOLD_LIMIT = `HOLD_TIME_US * `CORE_CLK_MHZ
) (
  input wire logic core_clk, // core clock, 250 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [ANALOG_W-1:0] inPos, // positive input level
  input wire logic [ANALOG_W-1:0] inNeg, // negative input level
  input wire logic [ANALOG_W-1:0] refLevel, // reference level
  input wire logic select_shutdown_n, // chip select / shutdown pin
  input wire logic serialClk, // serial clock pin from the host
  output logic dataOut, // serial data out
  output logic dataOutEn_n, // low while dataOut is driven
  output logic standby, // high in low-power standby
  output logic holdExpired // conversion outlasted the hold time
);
  import sar_adc_pkg::*;

  localparam int PROD_W = ANALOG_W + `CODE_SHIFT;
  localparam int HOLD_CNT_W = $clog2(HOLD_LIMIT + 1);

  if (ANALOG_W < `RESULT_W || ANALOG_W > 24 || HOLD_LIMIT < 1) begin : g_bad_param
    $error("analog width must be 12..24 and hold limit at least 1");
  end

  // the frame layout constants must agree with the result width
  if (`MSB_LAST_CLK - `NULL_CLK != `RESULT_W) begin : g_bad_msb_span
    $error("MSB-first span must equal the result width");
  end
  if (`LSB_LAST_CLK - `MSB_LAST_CLK != `RESULT_W - 1) begin : g_bad_lsb_span
    $error("LSB-first span must be the result width less one");
  end
  if (`CLK_CNT_MAX <= `LSB_LAST_CLK) begin : g_bad_cnt_w
    $error("clock counter cannot reach the zero tail");
  end
  if (`CLK_CNT_MAX != (1 << `CLK_CNT_W) - 1) begin : g_bad_cnt_max
    $error("clock counter ceiling must fill the counter width");
  end
  if (`CODE_SHIFT != `RESULT_W) begin : g_bad_scale
    $error("code scale must match the result width");
  end
  if (`SYNC_DONE >= `SYNC_CNT) begin : g_bad_sync
    $error("synchroniser positions exceed the synchroniser count");
  end

  // phase of the frame from the count of rising edges
  function automatic phase_e phaseOf(input logic [`CLK_CNT_W-1:0] clkNum);
    if (clkNum == '0) begin
      phaseOf = PH_IDLE;
    end else if (clkNum < `NULL_CLK) begin
      phaseOf = PH_ACQ;
    end else if (clkNum == `NULL_CLK) begin
      phaseOf = PH_NULL;
    end else if (clkNum <= `MSB_LAST_CLK) begin
      phaseOf = PH_MSB;
    end else if (clkNum <= `LSB_LAST_CLK) begin
      phaseOf = PH_LSB;
    end else begin
      phaseOf = PH_ZERO;
    end
  endfunction : phaseOf

  // the null-bit clock both ends sampling and turns the driver on
  function automatic logic isNullClk(input phase_e ph);
    isNullClk = (ph == PH_NULL);
  endfunction : isNullClk

  // one comparator step: keep the trial bit if vin*4096 >= trial*ref
  function automatic logic trialAccepts(input logic [ANALOG_W-1:0] vin,
                                        input logic [ANALOG_W-1:0] refV,
                                        input code_t trial);
    logic [PROD_W-1:0] scaled;
    logic [PROD_W-1:0] weight;
    scaled = {vin, `CODE_ZERO};
    weight = PROD_W'(trial) * PROD_W'(refV);
    trialAccepts = (scaled >= weight);
  endfunction : trialAccepts

  // ---------------- core domain ----------------
  logic [`SYNC_CNT-1:0] syncIn;
  wire logic [`SYNC_CNT-1:0] syncVal;
  logic armed_reg;
  logic linkRst_reg;
  logic [ANALOG_W-1:0] vinHeld_reg;
  logic [ANALOG_W-1:0] refHeld_reg;
  logic [HOLD_CNT_W-1:0] holdCount_reg;
  logic holdExpired_reg;
  logic trackWin;
  logic holdWin;

  // link domain registers
  logic [`CLK_CNT_W-1:0] clkCount_reg;
  logic started_reg;
  logic sampled_reg;
  logic done_reg;
  code_t code_reg;
  logic dataOut_reg;
  logic dataOutEn_n_reg;

  // the pin and the link-domain flags all reach the core through two flops
  assign syncIn[`SYNC_SEL] = select_shutdown_n;
  assign syncIn[`SYNC_START] = started_reg;
  assign syncIn[`SYNC_SAMPLED] = sampled_reg;
  assign syncIn[`SYNC_DONE] = done_reg;

  for (genvar i = 0; i < `SYNC_CNT; i++) begin : g_sync
    logic meta_reg;
    logic out_reg;
    always_ff @(posedge core_clk) begin
      if (srst) begin
        meta_reg <= 1'b0;
        out_reg <= 1'b0;
      end else begin
        meta_reg <= syncIn[i];
        out_reg <= meta_reg;
      end
    end
    assign syncVal[i] = out_reg;
  end

  // a select seen high since reset arms the device
  always_ff @(posedge core_clk) begin
    if (srst) begin
      armed_reg <= 1'b0;
    end else if (syncVal[`SYNC_SEL]) begin
      armed_reg <= 1'b1;
    end
  end

  // the link logic is held reset while select is high or not yet armed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      linkRst_reg <= 1'b1;
    end else begin
      linkRst_reg <= syncVal[`SYNC_SEL] | ~armed_reg;
    end
  end

  // acquisition: first rising edge until the null-bit edge is seen
  assign trackWin = syncVal[`SYNC_START] & ~syncVal[`SYNC_SAMPLED];
  // hold: end of sampling until the last MSB-first bit
  assign holdWin = syncVal[`SYNC_SAMPLED] & ~syncVal[`SYNC_DONE];

  // sample and hold: track while acquiring, freeze once sampling ends
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vinHeld_reg <= '0;
      refHeld_reg <= '0;
    end else if (trackWin) begin
      vinHeld_reg <= (inPos > inNeg) ? inPos - inNeg : '0;
      refHeld_reg <= refLevel;
    end
  end

  // time from end of sampling to the last MSB-first bit
  always_ff @(posedge core_clk) begin
    if (srst || !holdWin) begin
      holdCount_reg <= '0;
    end else if (holdCount_reg != HOLD_CNT_W'(HOLD_LIMIT)) begin
      holdCount_reg <= holdCount_reg + 1'b1;
    end
  end

  // flags a conversion whose held charge may have drooped
  always_ff @(posedge core_clk) begin
    if (srst || trackWin) begin
      holdExpired_reg <= 1'b0;
    end else if (holdWin && holdCount_reg == HOLD_CNT_W'(HOLD_LIMIT)) begin
      holdExpired_reg <= 1'b1;
    end
  end

  // ---------------- serial clock domain ----------------
  phase_e phase;
  logic [3:0] msbIdx;
  logic [3:0] lsbIdx;
  code_t trial;
  logic acceptBit;

  assign phase = phaseOf(clkCount_reg);
  assign msbIdx = 4'(`MSB_LAST_CLK - clkCount_reg);
  assign lsbIdx = 4'(clkCount_reg - `MSB_LAST_CLK);
  assign trial = code_reg | (code_t'(1) << msbIdx);
  // held words freeze a few core cycles after the null-bit edge; a serial
  // clock that reached its next falling edge before then would compare
  // against words that are still tracking
  assign acceptBit = trialAccepts(vinHeld_reg, refHeld_reg, trial);

  // rising edges after select falls number the clocks
  always_ff @(posedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      clkCount_reg <= '0;
    end else if (clkCount_reg != `CLK_CNT_MAX) begin
      clkCount_reg <= clkCount_reg + 1'b1;
    end
  end

  // first rising edge opens the acquisition window
  always_ff @(posedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // a falling edge before the first rising one does nothing (mode 1,1)
  always_ff @(negedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      sampled_reg <= 1'b0;
    end else if (isNullClk(phase)) begin
      sampled_reg <= 1'b1;
    end
  end

  // last MSB-first bit closes the hold window
  always_ff @(negedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      done_reg <= 1'b0;
    end else if (clkCount_reg == `MSB_LAST_CLK) begin
      done_reg <= 1'b1;
    end
  end

  // successive approximation, one bit per clock
  always_ff @(negedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      code_reg <= `CODE_ZERO;
    end else if (phase == PH_MSB) begin
      code_reg[msbIdx] <= acceptBit;
    end
  end

  // one bit per falling edge; the enable decides whether the pin shows it
  always_ff @(negedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      dataOut_reg <= 1'b0;
    end else begin
      case (phase)
        PH_NULL: begin
          dataOut_reg <= 1'b0;
        end
        PH_MSB: begin
          dataOut_reg <= acceptBit;
        end
        PH_LSB: begin
          dataOut_reg <= code_reg[lsbIdx];
        end
        PH_ZERO: begin
          dataOut_reg <= 1'b0;
        end
        default: begin
          dataOut_reg <= dataOut_reg;
        end
      endcase
    end
  end

  // driver turns on with the null bit and stays on until select rises
  always_ff @(negedge serialClk or posedge linkRst_reg) begin
    if (linkRst_reg) begin
      dataOutEn_n_reg <= 1'b1;
    end else if (isNullClk(phase)) begin
      dataOutEn_n_reg <= 1'b0;
    end
  end

  assign dataOut = dataOut_reg;
  assign dataOutEn_n = dataOutEn_n_reg;
  assign standby = linkRst_reg;
  assign holdExpired = holdExpired_reg;

endmodule : sar_adc_serial_readout

/* verif/sar_adc_serial_readout_bench.sv */
/* self-checking bench of the converter readout with a host model on the link.
   assumes the package and defines are compiled first */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((e) !== (a)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, e, a); end end
module sar_adc_serial_readout_bench;
  import sar_adc_pkg::*;
  logic core_clk, srst, select_shutdown_n, serialClk, dataOut, dataOutEn_n;
  logic standby, holdExpired, expH;
  logic [15:0] inPos, inNeg, refLevel;
  logic [63:0] expS;
  logic [63:0] expQ[$];
  logic holdQ[$];
  code_t codeQ[$];
  int lenQ[$];
  code_t expC;
  int expN;
  int n_fail, n_checks;
  sar_adc_serial_readout #(.ANALOG_W(16), .HOLD_LIMIT(500)) uut (.core_clk(core_clk),
    .srst(srst), .inPos(inPos), .inNeg(inNeg), .refLevel(refLevel),
    .select_shutdown_n(select_shutdown_n), .serialClk(serialClk), .dataOut(dataOut),
    .dataOutEn_n(dataOutEn_n), .standby(standby), .holdExpired(holdExpired));
  sar_host_model host (.select_shutdown_n(select_shutdown_n), .serialClk(serialClk),
    .dataOut(dataOut), .dataOutEn_n(dataOutEn_n));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic code_t conv(logic [15:0] p, logic [15:0] m, logic [15:0] r);
    longint d;
    d = longint'(p) - longint'(m);
    if (d <= 0) return 12'h000;
    if (r == 16'h0000 || d * 4096 / r > 4095) return 12'hFFF;
    return code_t'(d * 4096 / r);
  endfunction : conv
  // bit captured at rising i is the one driven after rising i-1
  function automatic logic [63:0] stream(code_t c, int n);
    logic [63:0] s;
    int i;
    s = '0;
    for (i = 3; i <= n; i++) begin
      s = s << 1;
      if (i >= 4 && i <= 15) s[0] = c[15 - i];
      else if (i >= 16 && i <= 26) s[0] = c[i - 15];
    end
    return s;
  endfunction : stream
  // byte host: drop the repeated bit one, move bit seven down, shift the high byte
  function automatic code_t realign(logic [63:0] s);
    logic [7:0] hiByte;
    logic [7:0] loByte;
    hiByte = {2'h0, s[13:8]};
    loByte = {hiByte[0], s[7:1]};
    hiByte = hiByte >> 1;
    return {hiByte[3:0], loByte};
  endfunction : realign
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    forever begin
      @(host.done);
      expS = expQ.pop_front();
      expH = holdQ.pop_front();
      expC = codeQ.pop_front();
      expN = lenQ.pop_front();
      `CHK("frame bits", expS, host.rx)
      `CHK("hold flag", expH, holdExpired)
      if (expN == 16) `CHK("realigned code", expC, realign(host.rx))
    end
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    int i, n;
    int lens[4] = '{8, 16, 26, 32};
    logic [15:0] p, m, r;
    srst = 1'b1;
    inPos = '0;
    inNeg = '0;
    refLevel = 16'hFFFF;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'hA349));
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (12) @(posedge core_clk);
    `CHK("standby", 1'b1, standby)
    for (i = 0; i < 12; i++) begin
      p = 16'($urandom);
      m = (i == 0) ? p + 16'h0001 : 16'($urandom % 64);
      r = (i == 1) ? 16'h0100 : 16'($urandom | 32'h100);
      n = lens[i % 4];
      @(posedge core_clk);
      inPos <= p;
      inNeg <= m;
      refLevel <= r;
      expQ.push_back(stream(conv(p, m, r), n));
      codeQ.push_back(conv(p, m, r));
      lenQ.push_back(n);
      holdQ.push_back(i == 5);
      host.frame(n, i[0], (i == 5) ? 125.0 : 40.0, (i == 5) ? 125.0 : 85.0);
    end
    // let the watcher take the last frame before the verdict
    repeat (4) @(posedge core_clk);
    `CHK("notes left", 0, expQ.size())
    print_verdict();
  end
endmodule : sar_adc_serial_readout_bench

/* verif/sar_adc_serial_readout_props.sv */
/* checker of the readout pins.
   assumes it is bound to the readout top and sees only its ports */
`timescale 1ns/1ps
module sar_adc_serial_readout_props (
  input wire logic core_clk, // core clock
  input wire logic srst, // reset
  input wire logic select_shutdown_n, // select pin
  input wire logic serialClk, // serial clock
  input wire logic dataOut, // serial data
  input wire logic dataOutEn_n, // low while driven
  input wire logic standby, // standby flag
  input wire logic holdExpired // hold flag
);
  logic [4:0] k; // rising edges since standby left
  logic [11:0] msb; // bits seen in the MSB-first copy
  always_ff @(posedge serialClk or posedge standby) begin
    if (standby) k <= 5'h00;
    else if (k != 5'h1F) k <= k + 5'h01;
  end
  always_ff @(posedge serialClk) begin
    if (k >= 5'h03 && k <= 5'h0E) msb[14 - k] <= dataOut;
  end
  a_abort_to_standby:
  assert property (@(posedge core_clk) disable iff (srst)
    $rose(select_shutdown_n) |-> ##[1:4] (standby && dataOutEn_n)) else $error("no abort");
  a_standby_quiet:
  assert property (@(posedge core_clk) disable iff (srst) standby |-> dataOutEn_n)
    else $error("driven in standby");
  a_change_on_fall:
  assert property (@(posedge core_clk) disable iff (srst)
    $changed(dataOut) && !standby && !$past(standby) |-> !serialClk) else $error("bad edge");
  a_tristate_early:
  assert property (@(posedge serialClk) disable iff (standby) k <= 5'h01 |-> dataOutEn_n)
    else $error("driven too early");
  a_null_bit:
  assert property (@(posedge serialClk) disable iff (standby)
    k == 5'h02 |-> !dataOutEn_n && !dataOut) else $error("no null bit");
  a_lsb_copy:
  assert property (@(posedge serialClk) disable iff (standby)
    k >= 5'h0F && k <= 5'h19 |-> dataOut == msb[k - 14]) else $error("bad LSB copy");
  a_zero_tail:
  assert property (@(posedge serialClk) disable iff (standby) k >= 5'h1A |-> !dataOut)
    else $error("tail not zero");
  a_reset_state:
  assert property (@(posedge core_clk) srst |=> standby && dataOutEn_n && !holdExpired)
    else $error("bad reset state");
  a_powerup_low:
  assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) && !select_shutdown_n |-> standby [*8]) else $error("started from low");
endmodule : sar_adc_serial_readout_props
bind sar_adc_serial_readout sar_adc_serial_readout_props chk (.core_clk(core_clk),
  .srst(srst), .select_shutdown_n(select_shutdown_n), .serialClk(serialClk),
  .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .standby(standby),
  .holdExpired(holdExpired));

/* verif/sar_host_model.sv */
/* host on the serial link: drives select and clock, captures on rising edges.
   assumes the readout drives dataOut under an active-low enable */
`timescale 1ns/1ps
module sar_host_model (
  output logic select_shutdown_n, // select pin
  output logic serialClk, // serial clock
  input wire logic dataOut, // serial data
  input wire logic dataOutEn_n // low while driven
);
  logic [63:0] rx; // bits from the third rising edge on
  logic lineBit; // released wire shows the inverse of the last bit
  event done;
  assign lineBit = dataOutEn_n ? ~rx[0] : dataOut;
  initial begin
    select_shutdown_n = 1'b0;
    serialClk = 1'b0;
    rx = '0;
  end
  task automatic frame(input int n, input bit idleHigh, input realtime hi, input realtime lo);
    int i;
    select_shutdown_n <= 1'b1;
    // idle level changes only once the readout is back in standby
    #100;
    serialClk <= idleHigh;
    rx = '0;
    #100;
    select_shutdown_n <= 1'b0;
    #40;
    for (i = 1; i <= n; i++) begin
      if (idleHigh) begin
        serialClk <= 1'b0;
        #lo;
      end
      serialClk <= 1'b1;
      if (i >= 3) rx = {rx[62:0], lineBit};
      #hi;
      if (!idleHigh) begin
        serialClk <= 1'b0;
        #lo;
      end
    end
    select_shutdown_n <= 1'b1;
    #100;
    -> done;
  endtask : frame
endmodule : sar_host_model
